// File: logic/sub_sysreg_exec.sv
// executes subtract, reverse subtract and system-register read in one cycle
// assumes insn comes from the decoder on clk; register port is a same-clock master
//
// Contract
// - system-register read copies the selected system register into the target gpr
// - system-register read changes no system register and no condition flag
// - subtract writes target minus source into target, source untouched
// - reverse subtract writes source minus target into target, source untouched
// - subtracts set carry on borrow out of the top bit, else clear
// - subtracts set wrap flag on signed overflow, clamp flag untouched
// - subtracts set negative flag when the result is negative
// - subtracts set null flag when the result is zero
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module sub_sysreg_exec
   import sub_exec_pkg::*;
#(
   parameter logic [NREG-1:0] SYSREG_IMPL = SYSREG_IMPL_DEFAULT
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic [XLEN-1:0] insn,
   input wire logic insn_valid,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [XLEN-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [XLEN-1:0] reg_rdata,
   output logic insn_done,
   output logic insn_bad,
   output logic carry_flag,
   output logic arith_wrap_flag,
   output logic negative_flag,
   output logic result_null_flag,
   output logic clamp_flag
);
   logic [XLEN-1:0] gpr_array [NREG];
   logic [XLEN-1:0] system_reg_array [NREG];
   logic [IDX_W-1:0] tgt_idx;
   logic [IDX_W-1:0] src_idx;
   logic [5:0] subop;
   logic [15:0] upper;
   op_t op;
   logic sr_impl;
   minus_if mif();

   // decoded fields
   assign tgt_idx = insn[TGT_HI:TGT_LO];
   assign src_idx = insn[SRC_HI:SRC_LO];
   assign subop = insn[SUBOP_HI:SUBOP_LO];
   assign upper = insn[UPPER_HI:UPPER_LO];
   assign sr_impl = SYSREG_IMPL[src_idx];

   // operation select; subtracts are halfword forms, so the upper half is not looked at
   always_comb begin
      op = OP_NONE;
      if (insn_valid) begin
         if (subop == SUBOP_SUB) begin
            op = OP_SUB;
         end else if (subop == SUBOP_REVERSE_MINUS_INSN) begin
            op = OP_REVERSE_MINUS_INSN;
         end else if (subop == SUBOP_SYSRD && upper == UPPER_ZERO) begin
            op = OP_SYSRD;
         end
      end
   end

   // one shared subtractor; operands swap for the reverse form
   always_comb begin
      if (op == OP_REVERSE_MINUS_INSN) begin
         mif.minuend = gpr_array[src_idx];
         mif.subtrahend = gpr_array[tgt_idx];
      end else begin
         mif.minuend = gpr_array[tgt_idx];
         mif.subtrahend = gpr_array[src_idx];
      end
   end

   minus_unit u_minus (
      .m(mif)
   );

   // register-port decode
   logic bus_gpr_we;
   logic bus_sr_we;
   logic bus_flag_we;
   always_comb begin
      bus_gpr_we = 1'b0;
      bus_sr_we = 1'b0;
      bus_flag_we = 1'b0;
      if (reg_wr && reg_addr < ADDR_SR_BASE) begin
         bus_gpr_we = 1'b1;
      end else if (reg_wr && reg_addr < ADDR_FLAGS) begin
         bus_sr_we = SYSREG_IMPL[reg_addr[IDX_W-1:0]];
      end else if (reg_wr && reg_addr == ADDR_FLAGS) begin
         bus_flag_we = 1'b1;
      end
   end

   // gpr write port of the executor; it is applied after the bus port, so it wins
   logic ex_we;
   logic [XLEN-1:0] ex_wdata;
   always_comb begin
      ex_we = 1'b0;
      ex_wdata = WORD_ZERO;
      if (op == OP_SUB || op == OP_REVERSE_MINUS_INSN) begin
         ex_we = 1'b1;
         ex_wdata = mif.diff;
      end else if (op == OP_SYSRD && sr_impl) begin
         // a reserved selector writes nothing; its result is not defined anyway
         ex_we = 1'b1;
         ex_wdata = system_reg_array[src_idx];
      end
   end

   // register files; the system registers are only written from the port
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < NREG; i++) begin
            gpr_array[i] <= WORD_ZERO;
            system_reg_array[i] <= WORD_ZERO;
         end
      end else begin
         if (bus_gpr_we) begin
            gpr_array[reg_addr[IDX_W-1:0]] <= reg_wdata;
         end
         if (ex_we) begin
            gpr_array[tgt_idx] <= ex_wdata;
         end
         if (bus_sr_we) begin
            system_reg_array[reg_addr[IDX_W-1:0]] <= reg_wdata;
         end
      end
   end

   // flag next values: port write first, a subtract's update overrides it
   logic next_carry;
   logic next_wrap;
   logic next_neg;
   logic next_null;
   logic next_clamp;
   always_comb begin
      next_carry = carry_flag;
      next_wrap = arith_wrap_flag;
      next_neg = negative_flag;
      next_null = result_null_flag;
      next_clamp = clamp_flag;
      if (bus_flag_we) begin
         next_carry = reg_wdata[FLAG_CY];
         next_wrap = reg_wdata[FLAG_OV];
         next_neg = reg_wdata[FLAG_S];
         next_null = reg_wdata[FLAG_Z];
         next_clamp = reg_wdata[FLAG_SAT];
      end
      // clamp is never touched by the subtracts
      if (op == OP_SUB || op == OP_REVERSE_MINUS_INSN) begin
         next_carry = mif.borrow;
         next_wrap = mif.wrap;
         next_neg = mif.neg;
         next_null = mif.zero;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         carry_flag <= FLAGS_RESET[FLAG_CY];
         arith_wrap_flag <= FLAGS_RESET[FLAG_OV];
         negative_flag <= FLAGS_RESET[FLAG_S];
         result_null_flag <= FLAGS_RESET[FLAG_Z];
         clamp_flag <= FLAGS_RESET[FLAG_SAT];
      end else begin
         carry_flag <= next_carry;
         arith_wrap_flag <= next_wrap;
         negative_flag <= next_neg;
         result_null_flag <= next_null;
         clamp_flag <= next_clamp;
      end
   end

   // completion pulses and read data; read data stand for one cycle only
   logic next_done;
   logic next_bad;
   logic [XLEN-1:0] next_rdata;
   always_comb begin
      next_done = insn_valid && op != OP_NONE && !(op == OP_SYSRD && !sr_impl);
      next_bad = insn_valid && !next_done;
      next_rdata = WORD_ZERO;
      if (reg_rd && reg_addr < ADDR_SR_BASE) begin
         next_rdata = gpr_array[reg_addr[IDX_W-1:0]];
      end else if (reg_rd && reg_addr < ADDR_FLAGS) begin
         next_rdata = system_reg_array[reg_addr[IDX_W-1:0]];
      end else if (reg_rd && reg_addr == ADDR_FLAGS) begin
         next_rdata[FLAG_CY] = carry_flag;
         next_rdata[FLAG_OV] = arith_wrap_flag;
         next_rdata[FLAG_S] = negative_flag;
         next_rdata[FLAG_Z] = result_null_flag;
         next_rdata[FLAG_SAT] = clamp_flag;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         insn_done <= 1'b0;
         insn_bad <= 1'b0;
         reg_rdata <= WORD_ZERO;
      end else begin
         insn_done <= next_done;
         insn_bad <= next_bad;
         reg_rdata <= next_rdata;
      end
   end

   // checks on the executor
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_sub_go;
      op == OP_SUB;
   endsequence
   sequence s_reverse_minus_insn_go;
      op == OP_REVERSE_MINUS_INSN;
   endsequence
   sequence s_minus_go;
      op == OP_SUB || op == OP_REVERSE_MINUS_INSN;
   endsequence
   sequence s_sysrd_go;
      op == OP_SYSRD && sr_impl;
   endsequence

   a_decode_fields: assert property (
      insn_valid && insn[SUBOP_HI:SUBOP_LO] == SUBOP_REVERSE_MINUS_INSN |-> op == OP_REVERSE_MINUS_INSN)
      else $error("reverse subtract not decoded from bits 10..5");
   a_sub_value: assert property (
      s_sub_go |=> gpr_array[$past(tgt_idx)] ==
         $past(gpr_array[tgt_idx] - gpr_array[src_idx]))
      else $error("subtract result wrong");
   a_reverse_minus_insn_value: assert property (
      s_reverse_minus_insn_go |=> gpr_array[$past(tgt_idx)] ==
         $past(gpr_array[src_idx] - gpr_array[tgt_idx]))
      else $error("reverse subtract result wrong");
   a_source_kept: assert property (
      s_minus_go ##0 (src_idx != tgt_idx && !bus_gpr_we) |=>
         gpr_array[$past(src_idx)] == $past(gpr_array[src_idx]))
      else $error("source register changed by subtract");
   a_carry_borrow: assert property (
      s_minus_go |=> carry_flag == $past(mif.minuend < mif.subtrahend))
      else $error("carry does not match borrow");
   a_wrap_signed: assert property (
      s_minus_go |=> arith_wrap_flag ==
         $past(($signed(mif.minuend) < $signed(mif.subtrahend)) != mif.diff[XLEN-1]))
      else $error("wrap flag does not match signed overflow");
   a_neg_result: assert property (
      s_minus_go |=> negative_flag == gpr_array[$past(tgt_idx)][XLEN-1])
      else $error("negative flag does not match result");
   a_null_result: assert property (
      s_minus_go |=> result_null_flag == (gpr_array[$past(tgt_idx)] == WORD_ZERO))
      else $error("null flag does not match result");
   a_clamp_hold: assert property (
      s_minus_go ##0 !bus_flag_we |=> $stable(clamp_flag))
      else $error("clamp flag changed by subtract");
   a_sysrd_copy: assert property (
      s_sysrd_go |=> gpr_array[$past(tgt_idx)] == $past(system_reg_array[src_idx]))
      else $error("system register copy wrong");
   a_sysrd_still: assert property (
      s_sysrd_go ##0 !reg_wr |=> $stable(carry_flag) && $stable(arith_wrap_flag) &&
         $stable(negative_flag) && $stable(result_null_flag) && $stable(clamp_flag) &&
         system_reg_array[$past(src_idx)] == $past(system_reg_array[src_idx]))
      else $error("system register read disturbed state");

   // completion pulses and the upper-half check of the system-register read
   sequence s_sysrd_hdr_ok;
      insn_valid && subop == SUBOP_SYSRD && upper == UPPER_ZERO;
   endsequence
   sequence s_sysrd_hdr_bad;
      insn_valid && subop == SUBOP_SYSRD && upper != UPPER_ZERO;
   endsequence
   sequence s_pulse_clear;
      !insn_done && !insn_bad;
   endsequence

   a_decode_sysrd: assert property (
      s_sysrd_hdr_ok |-> op == OP_SYSRD)
      else $error("system register read not decoded");
   a_decode_sub: assert property (
      insn_valid && insn[SUBOP_HI:SUBOP_LO] == SUBOP_SUB |-> op == OP_SUB)
      else $error("subtract not decoded from bits 10..5");
   a_minus_done: assert property (
      s_minus_go |=> insn_done && !insn_bad)
      else $error("subtract did not report done");
   a_sysrd_done: assert property (
      s_sysrd_go |=> insn_done && !insn_bad)
      else $error("system register read did not report done");
   // a nonzero upper half means some other instruction, so it must be refused
   a_sysrd_upper: assert property (
      s_sysrd_hdr_bad |=> insn_bad && !insn_done)
      else $error("system register read taken with nonzero upper half");
   a_idle_quiet: assert property (
      !insn_valid |=> s_pulse_clear)
      else $error("done or bad raised without an instruction");
   a_reverse_minus_insn_source: assert property (
      s_reverse_minus_insn_go ##0 (src_idx != tgt_idx && !bus_gpr_we) |=>
         gpr_array[$past(src_idx)] == $past(gpr_array[src_idx]))
      else $error("source register changed by reverse subtract");
endmodule

// File: pkg/sub_exec_pkg.sv
// constants and types shared by the subtract / system-register read datapath
// assumes a 32-bit core with 32 general registers and 32 system register slots
package sub_exec_pkg;
   localparam int XLEN = 32;
   localparam int NREG = 32;
   localparam int IDX_W = 5;
   localparam int ADDR_W = 7;

   // instruction field positions
   localparam int TGT_HI = 15;
   localparam int TGT_LO = 11;
   localparam int SUBOP_HI = 10;
   localparam int SUBOP_LO = 5;
   localparam int SRC_HI = 4;
   localparam int SRC_LO = 0;
   localparam int UPPER_HI = 31;
   localparam int UPPER_LO = 16;

   // sub-opcodes
   localparam logic [5:0] SUBOP_SYSRD = 6'h3f;
   localparam logic [5:0] SUBOP_SUB = 6'h0d;
   localparam logic [5:0] SUBOP_REVERSE_MINUS_INSN = 6'h0c;
   localparam logic [15:0] UPPER_ZERO = 16'h0000;

   // register port map: gprs, then system registers, then the flag word
   localparam logic [ADDR_W-1:0] ADDR_GPR_BASE = 7'h00;
   localparam logic [ADDR_W-1:0] ADDR_SR_BASE = 7'h20;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS = 7'h40;

   // bit positions inside the flag word
   localparam int FLAG_Z = 0;
   localparam int FLAG_S = 1;
   localparam int FLAG_OV = 2;
   localparam int FLAG_CY = 3;
   localparam int FLAG_SAT = 4;

   // reset values
   localparam logic [XLEN-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   localparam logic [NREG-1:0] SYSREG_IMPL_DEFAULT = 32'hffff_ffff;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_SUB = 2'b01,
      OP_REVERSE_MINUS_INSN = 2'b10,
      OP_SYSRD = 2'b11
   } op_t;
endpackage

// File: pkg/minus_if.sv
// operand and result bundle between the executor and its subtractor
// assumes one clock domain; the subtractor is purely combinational
`timescale 1ns/1ns
interface minus_if;
   logic [31:0] minuend;
   logic [31:0] subtrahend;
   logic [31:0] diff;
   logic borrow;
   logic wrap;
   logic neg;
   logic zero;
   modport unit(input minuend, input subtrahend,
                output diff, output borrow, output wrap, output neg, output zero);
   modport user(output minuend, output subtrahend,
                input diff, input borrow, input wrap, input neg, input zero);
endinterface

// File: logic/minus_unit.sv
// 32-bit subtractor with borrow, signed wrap, sign and zero outputs
// assumes the caller registers the results; no state here
`timescale 1ns/1ns
module minus_unit
   import sub_exec_pkg::*;
(
   minus_if.unit m
);
   logic [XLEN:0] wide;

   // one extra bit catches the borrow out of the top bit
   always_comb begin
      wide = {1'b0, m.minuend} - {1'b0, m.subtrahend};
   end

   assign m.diff = wide[XLEN-1:0];
   assign m.borrow = wide[XLEN];
   // wrap only when operand signs differ and the result sign leaves the minuend's
   assign m.wrap = (m.minuend[XLEN-1] != m.subtrahend[XLEN-1]) &&
                   (m.diff[XLEN-1] != m.minuend[XLEN-1]);
   assign m.neg = m.diff[XLEN-1];
   assign m.zero = (m.diff == WORD_ZERO);
endmodule

// File: verification/test_sub_sysreg_exec.sv
// self-checking bench for the subtract / system-register read executor
// assumes the design's register port and instruction port contracts; no partner model
`timescale 1ns/1ns
`define CHK(nm, exp, got) \
   checks_done++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
   end
module test_sub_sysreg_exec;
   import sub_exec_pkg::*;
   // slots 0 and 31 left unimplemented so ignored port writes get exercised
   localparam logic [NREG-1:0] IMPL = 32'h7fff_fffe;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [XLEN-1:0] insn = 32'h0000_0000;
   logic insn_valid = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 7'h00;
   logic [XLEN-1:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [XLEN-1:0] reg_rdata;
   logic insn_done, insn_bad, carry_flag, arith_wrap_flag, negative_flag;
   logic result_null_flag, clamp_flag;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0000_0047;
   logic [31:0] gm[32];
   logic [31:0] sm[32];
   logic [4:0] fm = 5'h00;
   logic [31:0] rd_q[$];
   logic [6:0] ev_q[$];
   logic [31:0] re;
   logic [6:0] ee;
   logic rd_seen = 1'b0;
   logic iv_seen = 1'b0;
   logic [31:0] av[6] = '{32'h5, 32'h3, 32'h8000_0000, 32'h7fff_ffff, 32'h7, 32'h0};
   logic [31:0] bv[6] = '{32'h3, 32'h5, 32'h1, 32'hffff_ffff, 32'h7, 32'h0};

   sub_sysreg_exec #(.SYSREG_IMPL(IMPL)) u_sub_sysreg_exec (.clk(clk), .srst(srst),
      .insn(insn), .insn_valid(insn_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .insn_done(insn_done),
      .insn_bad(insn_bad), .carry_flag(carry_flag), .arith_wrap_flag(arith_wrap_flag),
      .negative_flag(negative_flag), .result_null_flag(result_null_flag),
      .clamp_flag(clamp_flag));

   initial forever #25 clk = ~clk;

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task close_out();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // every input is set once per edge, so back-to-back requests never double-assign
   task step(input logic w, r, v, input logic [6:0] a, input logic [31:0] d, i);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= r;
      insn_valid <= v;
      reg_addr <= a;
      reg_wdata <= d;
      insn <= i;
   endtask

   task wr(input logic [6:0] a, input logic [31:0] d);
      if (a < ADDR_SR_BASE) gm[a[4:0]] = d;
      else if (a < ADDR_FLAGS && IMPL[a[4:0]]) sm[a[4:0]] = d;
      else if (a == ADDR_FLAGS) fm = d[4:0];
      step(1'b1, 1'b0, 1'b0, a, d, 32'h0000_0000);
   endtask

   task rd(input logic [6:0] a);
      if (a < ADDR_SR_BASE) rd_q.push_back(gm[a[4:0]]);
      else if (a < ADDR_FLAGS) rd_q.push_back(sm[a[4:0]]);
      else if (a == ADDR_FLAGS) rd_q.push_back({27'h0, fm});
      else rd_q.push_back(32'h0000_0000);
      step(1'b0, 1'b1, 1'b0, a, 32'h0000_0000, 32'h0000_0000);
   endtask

   // reference model of one instruction, then issue it
   task ex(input logic [5:0] op, input logic [4:0] t, s, input logic [15:0] up);
      logic [31:0] a, b, dif;
      logic ok;
      ok = 1'b1;
      if (op == SUBOP_SYSRD && !IMPL[s]) s = 5'h01; // reserved slots never issued
      if (op == SUBOP_SUB || op == SUBOP_REVERSE_MINUS_INSN) begin
         a = (op == SUBOP_SUB) ? gm[t] : gm[s];
         b = (op == SUBOP_SUB) ? gm[s] : gm[t];
         dif = a - b;
         gm[t] = dif;
         fm[FLAG_CY] = a < b;
         fm[FLAG_OV] = (a[31] != b[31]) && (dif[31] != a[31]);
         fm[FLAG_S] = dif[31];
         fm[FLAG_Z] = dif == 32'h0000_0000;
      end else if (op == SUBOP_SYSRD && up == UPPER_ZERO && IMPL[s]) begin
         gm[t] = sm[s];
      end else begin
         ok = 1'b0;
      end
      ev_q.push_back({ok, !ok, fm});
      step(1'b0, 1'b0, 1'b1, 7'h00, 32'h0000_0000, {up, t, op, s});
   endtask

   // watcher: results land one edge after the request, sampled at the settled falling edge
   always @(negedge clk) begin
      if (rd_seen) begin
         re = rd_q.pop_front();
         `CHK("read data", re, reg_rdata)
      end else begin
         `CHK("idle read data", 32'h0000_0000, reg_rdata)
      end
      if (iv_seen) begin
         ee = ev_q.pop_front();
         `CHK("done and bad", ee[6:5], {insn_done, insn_bad})
         `CHK("carry", ee[FLAG_CY], carry_flag)
         `CHK("wrap", ee[FLAG_OV], arith_wrap_flag)
         `CHK("negative", ee[FLAG_S], negative_flag)
         `CHK("null", ee[FLAG_Z], result_null_flag)
         `CHK("clamp", ee[FLAG_SAT], clamp_flag)
      end else begin
         `CHK("idle status", 2'b00, {insn_done, insn_bad})
      end
      rd_seen = reg_rd;
      iv_seen = insn_valid;
   end

   // hang guard, well above the roughly 640 cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("timeout after %0d cycles", cycles);
         close_out();
      end
   end

   initial begin
      for (int i = 0; i < 32; i++) begin
         gm[i] = 32'h0000_0000;
         sm[i] = 32'h0000_0000;
      end
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(ADDR_FLAGS);
      rd(7'h05);
      rd(7'h25);
      $display("test reset values done");
      wr(ADDR_FLAGS, 32'h0000_0010);
      wr(7'h41, 32'hdead_0001);
      wr(7'h20, 32'h1234_5678);
      wr(7'h3f, 32'h8765_4321);
      for (int i = 0; i < 4; i++) rd(i == 0 ? 7'h20 : i == 1 ? 7'h3f : i == 2 ? 7'h41 : 7'h7f);
      $display("test register port done");
      // boundary operands, both directions, sources read back afterwards
      for (int i = 0; i < 6; i++) begin
         wr(7'h01, av[i]);
         wr(7'h02, bv[i]);
         ex(SUBOP_SUB, 5'd1, 5'd2, 16'h0000);
         wr(7'h03, av[i]);
         wr(7'h04, bv[i]);
         ex(SUBOP_REVERSE_MINUS_INSN, 5'd3, 5'd4, 16'h0000);
         for (int k = 1; k < 5; k++) rd(7'(k));
      end
      ex(SUBOP_SUB, 5'd9, 5'd9, 16'h0000);
      $display("test subtract boundaries done");
      for (int i = 0; i < 32; i++) wr(ADDR_SR_BASE + 7'(i), rnd());
      for (int i = 0; i < 32; i++) ex(SUBOP_SYSRD, 5'(31 - i), 5'(i), 16'h0000);
      ex(SUBOP_SYSRD, 5'd5, 5'd3, 16'h0001);
      for (int k = 0; k < 64; k++) ex(k[5:0], 5'(rnd()), 5'(rnd()), 16'h0000);
      for (int i = 0; i < 64; i++) rd(7'(i));
      $display("test system register read done");
      repeat (300) begin
         re = rnd();
         case (re[1:0])
            2'd0: ex(SUBOP_SUB, re[6:2], re[11:7], 16'h0000);
            2'd1: ex(SUBOP_REVERSE_MINUS_INSN, re[6:2], re[11:7], 16'h0000);
            2'd2: ex(SUBOP_SYSRD, re[6:2], re[11:7], {15'h0, re[12]});
            default: wr({2'b00, re[6:2]}, rnd());
         endcase
      end
      for (int i = 0; i < 65; i++) rd(7'(i));
      $display("test random mix done");
      step(1'b0, 1'b0, 1'b0, 7'h00, 32'h0000_0000, 32'h0000_0000);
      repeat (3) @(posedge clk);
      close_out();
   end
endmodule
